/* File: design/tra_top.sv */
// Terminal rate adapter data path: terminal port, time-slotted network port, FIFOs and bus.
// Assumes all pins except the network port are asynchronous to i_clk_sys.
`timescale 1ns/1ns
// Function
// - Network receive bit is sampled on falling network clock edges.
// - Network transmit bit changes on rising network clock edges.
// - Synchronous terminal transmit data latched on rising bit timing edge.
// - Terminal receive data changes on falling bit timing edge.
// - Bearer rate is 2^n x 8 kbps, n selectable 0 to 3.
// - Sync pass-through skips async conversion; otherwise network rate is independent.
// - Up to eight terminals share a 64 kbps channel through subchannels.
// - User data speed programmable from 300 bps to 64 kbps.
// - Open-drain interrupt pulled active only while a request is pending.
// - Data multiplexer routes terminal, rate stage and serial logic per mode.
// - USART and HDLC sections each have FIFOs reached by bus or DMA.
// - Intermediate and bearer stages perform RA1 and RA2 adaptation.
// - Async converter adjusts stop elements and handles break signals.
// - Local and remote state changes are detected and shown to software.
// - Test loops return local and remote data toward their origin.
// - Synchronous terminals run X.21 or X.21 bis with interworking.
// - Terminal bit timing derives from the local clock, aligned to the network frame.
// - Address is captured from the bus while the latch strobe is high.
// - DMA request raised per byte; controller answers with matching acknowledge.
// - Time channel placed relative to frame sync, up to 512 bits per frame.
// - Terminal control circuits show OFF high and ON low.
module tra_top #(
  parameter int FIFO_DEPTH = tra_pkg::FIFO_DEPTH_DEF,
  parameter int BREAK_BITS = tra_pkg::BREAK_BITS_DEF
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire logic                 i_net_clk,
  input  wire logic                 i_frame_sync_8k,
  input  wire logic                 i_net_serial_in,
  output logic                      o_net_serial_out,
  input  wire tra_pkg::tra_cfg_type i_cfg,
  input  wire tra_pkg::tra_pins_type i_pins,
  input  wire logic [7:0]           i_ad,
  output logic [7:0]                o_ad_out,
  output logic                      o_ad_oe,
  output logic                      o_term_rxd,
  output logic                      o_bit_timing,
  output logic [2:0]                o_term_ctl_n,
  output logic                      o_irq_n_out,
  output logic                      o_irq_oe,
  output logic                      o_dma_out_request,
  output logic                      o_dma_in_request,
  output logic                      o_end_of_dma_out_req
);
  localparam int AW = $clog2(FIFO_DEPTH);

  // Link clock domain
  logic [1:0] lrst_q;
  tra_pkg::tra_cfg_type lcfg1_q, lcfg2_q;
  logic [9:0] cnt_q, cnt_d, base, pos;
  logic [7:0] racc_q, racc_d, rbyte_q, rbyte_d, thold_q, thold_d;
  logic       rtog_q, rtog_d, fsp_q, fsp_d, win, tx_q, tx_d;
  logic [2:0] ttog_s_q;
  logic       lrst;
  logic [7:0] tx_word_q, tx_word_d;
  logic       ttog_q, ttog_d;

  assign lrst = lrst_q[1];
  always_ff @(posedge i_net_clk) begin
    lrst_q  <= {lrst_q[0], i_rst};
    lcfg1_q <= i_cfg;
    lcfg2_q <= lcfg1_q;
  end

  always_comb begin
    base = {1'b0, lcfg2_q.slot} + 10'({7'h00, lcfg2_q.subch} << lcfg2_q.n_exp);
    pos  = cnt_q - base;
    win  = (cnt_q >= base) && (pos < (10'h001 << lcfg2_q.n_exp));
    cnt_d   = (cnt_q == tra_pkg::CNT_LAST) ? cnt_q : cnt_q + 10'h001;
    racc_d  = racc_q;
    rbyte_d = rbyte_q;
    rtog_d  = rtog_q;
    fsp_d   = i_frame_sync_8k;
    if (win)
      racc_d[pos[2:0]] = i_net_serial_in;
    if (i_frame_sync_8k && !fsp_q) begin
      cnt_d   = 10'h000;
      rbyte_d = racc_d;
      racc_d  = tra_pkg::ACC_RST;
      rtog_d  = ~rtog_q;
    end
    tx_d    = win ? thold_q[pos[2:0]] : 1'b1;
    thold_d = (ttog_s_q[2] != ttog_s_q[1]) ? tx_word_q : thold_q;
  end

  always_ff @(negedge i_net_clk) begin
    if (lrst) begin
      cnt_q   <= tra_pkg::CNT_LAST;
      racc_q  <= tra_pkg::ACC_RST;
      rbyte_q <= tra_pkg::IDLE_WORD;
      rtog_q  <= 1'b0;
      fsp_q   <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      racc_q  <= racc_d;
      rbyte_q <= rbyte_d;
      rtog_q  <= rtog_d;
      fsp_q   <= fsp_d;
    end
  end

  always_ff @(posedge i_net_clk) begin
    if (lrst) begin
      ttog_s_q <= 3'h0;
      thold_q  <= tra_pkg::IDLE_WORD;
      tx_q     <= 1'b1;
    end else begin
      ttog_s_q <= {ttog_s_q[1:0], ttog_q};
      thold_q  <= thold_d;
      tx_q     <= tx_d;
    end
  end
  assign o_net_serial_out = tx_q;

  a_net_rx_sample: assert property (@(negedge i_net_clk) disable iff (lrst)
    win && !(i_frame_sync_8k && !fsp_q) |=> racc_q[$past(pos[2:0])] == $past(i_net_serial_in))
    else $error("network bit not captured");
  a_net_tx_idle: assert property (@(posedge i_net_clk) disable iff (lrst)
    !win |=> o_net_serial_out) else $error("transmit driven outside time channel");
  a_frame_restart: assert property (@(negedge i_net_clk) disable iff (lrst)
    i_frame_sync_8k && !fsp_q |=> cnt_q == 10'h000 && rtog_q != $past(rtog_q))
    else $error("frame start not taken");

  // System domain: pin synchronisers
  tra_pkg::tra_pins_type p1_q, p2_q, pp_q;
  tra_pkg::tra_cfg_type  c1_q, cfg;
  logic [7:0] a1_q, ad_s;
  logic [2:0] rtog_s_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      p1_q <= tra_pkg::PINS_RST;
      p2_q <= tra_pkg::PINS_RST;
      pp_q <= tra_pkg::PINS_RST;
      rtog_s_q <= 3'h0;
    end else begin
      p1_q <= i_pins;
      p2_q <= p1_q;
      pp_q <= p2_q;
      rtog_s_q <= {rtog_s_q[1:0], rtog_q};
    end
    c1_q <= i_cfg;
    cfg  <= c1_q;
    a1_q <= i_ad;
    ad_s <= a1_q;
  end

  logic ev, fifo_mode, sec, rd_act, rd_end, wr_end, din_end, dout_end;
  assign ev        = rtog_s_q[2] != rtog_s_q[1];
  assign fifo_mode = cfg.mode == tra_pkg::MODE_USART || cfg.mode == tra_pkg::MODE_HDLC;
  assign sec       = cfg.mode == tra_pkg::MODE_HDLC;
  assign rd_act    = !p2_q.cs_n && !p2_q.rd_n;
  assign rd_end    = !pp_q.cs_n && !pp_q.rd_n && !rd_act;
  assign wr_end    = !pp_q.cs_n && !pp_q.wr_n && (p2_q.cs_n || p2_q.wr_n);
  assign din_end   = pp_q.din_ack && !p2_q.din_ack;
  assign dout_end  = pp_q.dout_ack && !p2_q.dout_ack;

  // Four FIFOs: 0/1 receive USART/HDLC, 2/3 transmit USART/HDLC
  logic [7:0]  mem_q [4][FIFO_DEPTH];
  logic [AW:0] fcnt_q [4];
  logic [AW-1:0] rp_q [4], wp_q [4];
  logic [3:0]  push, pop, full, empty;
  logic [7:0]  din [4], head [4];
  logic [7:0]  addr_q, addr_d;
  genvar f;
  generate
    for (f = 0; f < 4; f++) begin : g_fifo
      localparam bit IS_TX = f >= 2;
      localparam bit FSEC = (f % 2) == 1;
      logic [AW:0] fcnt_d;
      logic [AW-1:0] rp_d, wp_d;
      assign full[f]  = fcnt_q[f] == (AW+1)'(FIFO_DEPTH);
      assign empty[f] = fcnt_q[f] == '0;
      assign head[f]  = mem_q[f][rp_q[f]];
      always_comb begin
        if (IS_TX) begin
          push[f] = !full[f] && ((wr_end && addr_q[0] == FSEC && addr_q[7:1] == 7'h00)
                    || (din_end && sec == FSEC));
          pop[f]  = !empty[f] && ev && fifo_mode && sec == FSEC;
          din[f]  = ad_s;
        end else begin
          push[f] = !full[f] && ev && fifo_mode && sec == FSEC;
          pop[f]  = !empty[f] && ((rd_end && addr_q[0] == FSEC && addr_q[7:1] == 7'h00)
                    || (dout_end && sec == FSEC));
          din[f]  = rbyte_q;
        end
        wp_d   = push[f] ? AW'(wp_q[f] + 1'b1) : wp_q[f];
        rp_d   = pop[f] ? AW'(rp_q[f] + 1'b1) : rp_q[f];
        fcnt_d = fcnt_q[f] + (AW+1)'(push[f]) - (AW+1)'(pop[f]);
      end
      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          fcnt_q[f] <= '0;
          rp_q[f]   <= '0;
          wp_q[f]   <= '0;
        end else begin
          fcnt_q[f] <= fcnt_d;
          rp_q[f]   <= rp_d;
          wp_q[f]   <= wp_d;
        end
        if (push[f])
          mem_q[f][wp_q[f]] <= din[f];
      end
    end
  endgenerate

  // Terminal timing, rate conversion, multiplexer and status
  logic [15:0] div_q, div_d, half;
  logic        s_q, s_d, s_rise, s_fall, rxd_q, rxd_d, brk_q, brk_d;
  logic [7:0]  acc_q, acc_d, rsh_q, rsh_d, stat_q, stat_d, pend_q, pend_d, ado_q, ado_d;
  logic [7:0]  brk_cnt_q, brk_cnt_d;
  logic [2:0]  ctl_q, ctl_d;
  logic        remote_on, rem_q, rem_d;
  assign half      = tra_pkg::half_period(cfg.rate_sel);
  assign s_rise    = (div_q >= half - 16'h0001) && !s_q;
  assign s_fall    = (div_q >= half - 16'h0001) && s_q;
  assign remote_on = rem_q;

  always_comb begin
    div_d = (div_q >= half - 16'h0001 || ev) ? 16'h0000 : div_q + 16'h0001;
    s_d   = (s_rise || s_fall) ? ~s_q : s_q;
    acc_d = s_rise ? {acc_q[6:0], p2_q.txd} : acc_q;
    rsh_d = s_fall ? {rsh_q[6:0], 1'b1} : rsh_q;
    rxd_d = rxd_q;
    if (s_fall)
      rxd_d = (cfg.mode == tra_pkg::MODE_LOOP_LOCAL) ? acc_q[0] : rsh_q[7];
    brk_cnt_d = brk_cnt_q;
    if (s_rise)
      brk_cnt_d = p2_q.txd ? 8'h00 : (brk_cnt_q == 8'hFF ? brk_cnt_q : brk_cnt_q + 8'h01);
    brk_d = (cfg.mode == tra_pkg::MODE_ASYNC) && (brk_cnt_q >= 8'(BREAK_BITS));
    tx_word_d = tx_word_q;
    ttog_d    = ttog_q;
    if (ev) begin
      case (cfg.mode)
        tra_pkg::MODE_USART, tra_pkg::MODE_HDLC:
          tx_word_d = empty[{1'b1, sec}] ? tra_pkg::IDLE_WORD : head[{1'b1, sec}];
        tra_pkg::MODE_LOOP_REMOTE: tx_word_d = rbyte_q;
        tra_pkg::MODE_SYNC_THRU:   tx_word_d = acc_q;
        default:                   tx_word_d = brk_q ? 8'h00 : acc_q;
      endcase
      ttog_d = ~ttog_q;
      acc_d  = s_rise ? {7'h7F, p2_q.txd} : tra_pkg::ACC_RST;
      rsh_d  = rbyte_q;
    end
    // Received byte is only stable for the system side at the frame event
    rem_d  = ev ? !rbyte_q[0] : rem_q;
    stat_d = {4'h0, brk_q, remote_on, !p2_q.rts_n, !p2_q.dtr_n};
    pend_d = (pend_q & ~((rd_end && addr_q == tra_pkg::ADDR_STAT) ? 8'hFF : 8'h00))
             | (stat_d ^ stat_q);
    // X.21 uses only indicate; X.21 bis adds ready and clear-to-send
    ctl_d = {remote_on, cfg.x21bis && !p2_q.dtr_n, cfg.x21bis && !p2_q.rts_n};
    addr_d = p2_q.ale ? ad_s : addr_q;
    if (addr_q == tra_pkg::ADDR_STAT)
      ado_d = pend_q;
    else
      ado_d = head[{1'b0, p2_q.dout_ack ? sec : addr_q[0]}];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      div_q <= 16'h0000;
      s_q <= 1'b0;
      acc_q <= tra_pkg::ACC_RST;
      rsh_q <= tra_pkg::ACC_RST;
      rxd_q <= 1'b1;
      brk_cnt_q <= 8'h00;
      brk_q <= 1'b0;
      tx_word_q <= tra_pkg::IDLE_WORD;
      ttog_q <= 1'b0;
      stat_q <= 8'h00;
      rem_q <= 1'b0;
      pend_q <= 8'h00;
      ctl_q <= 3'h0;
      addr_q <= 8'h00;
      ado_q <= 8'h00;
    end else begin
      div_q <= div_d;
      s_q <= s_d;
      acc_q <= acc_d;
      rsh_q <= rsh_d;
      rxd_q <= rxd_d;
      brk_cnt_q <= brk_cnt_d;
      brk_q <= brk_d;
      tx_word_q <= tx_word_d;
      ttog_q <= ttog_d;
      stat_q <= stat_d;
      rem_q <= rem_d;
      pend_q <= pend_d;
      ctl_q <= ctl_d;
      addr_q <= addr_d;
      ado_q <= ado_d;
    end
  end

  assign o_bit_timing = s_q;
  assign o_term_rxd   = rxd_q;
  assign o_term_ctl_n = ~ctl_q;
  assign o_irq_n_out  = 1'b0;
  assign o_irq_oe     = |pend_q;
  assign o_ad_out     = ado_q;
  assign o_ad_oe      = rd_act || p2_q.dout_ack;
  assign o_dma_in_request  = !i_rst && cfg.dma_en && fifo_mode && !full[{1'b1, sec}];
  assign o_dma_out_request = !i_rst && cfg.dma_en && fifo_mode && !empty[{1'b0, sec}];
  assign o_end_of_dma_out_req = o_dma_out_request && sec && fcnt_q[1] == (AW+1)'(1);

  a_irq_on_change: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    stat_d != stat_q |=> o_irq_oe) else $error("state change raised no interrupt");
  a_dma_after_rst: assert property (@(posedge i_clk_sys)
    i_rst |-> (!o_dma_in_request && !o_dma_out_request) ##1 !o_irq_oe)
    else $error("requests during reset");
  a_term_tx_latch: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_rise && !ev |=> acc_q[0] == $past(p2_q.txd))
    else $error("terminal bit not latched on rise");
  a_term_rx_edge: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_term_rxd) |-> $past(s_fall))
    else $error("receive data moved off falling edge");
  a_dma_in_full: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    full[{1'b1, sec}] |-> !o_dma_in_request) else $error("input request while FIFO full");
  a_ctl_level: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    p2_q.rts_n || !cfg.x21bis |=> o_term_ctl_n[0]) else $error("clear-to-send not OFF high");
endmodule // tra_top

/* File: design/tra_pkg.sv */
// Constants, carrier types and rate table for the terminal rate adapter.
// Assumes a 10 MHz system clock and a network bit clock of up to 4.096 MHz.
package tra_pkg;
  localparam int CLK_HZ         = 10_000_000;
  localparam int XTAL_HZ        = 10_752_000;
  localparam int FRAME_HZ       = 8_000;
  localparam int BEARER_UNIT_BPS = 8_000;
  localparam int MAX_FRAME_BITS = 512;
  localparam int FIFO_DEPTH_DEF = 4;
  localparam int BREAK_BITS_DEF = 20;
  localparam int NUM_RATES      = 11;
  localparam int USER_BPS [0:NUM_RATES-1] =
    '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 48000, 56000, 64000};
  localparam logic [9:0] CNT_LAST   = 10'(MAX_FRAME_BITS - 1);
  localparam logic [7:0] ADDR_USART = 8'h00;
  localparam logic [7:0] ADDR_HDLC  = 8'h01;
  localparam logic [7:0] ADDR_STAT  = 8'h02;
  localparam logic [7:0] IDLE_WORD  = 8'hFF;
  localparam logic [7:0] ACC_RST    = 8'hFF;

  typedef enum logic [2:0] {
    MODE_ASYNC, MODE_SYNC_THRU, MODE_USART, MODE_HDLC, MODE_LOOP_LOCAL, MODE_LOOP_REMOTE
  } tra_mode_type;

  typedef struct packed {
    logic [1:0]   n_exp;
    logic [8:0]   slot;
    logic [2:0]   subch;
    logic [3:0]   rate_sel;
    tra_mode_type mode;
    logic         x21bis;
    logic         dma_en;
  } tra_cfg_type;

  typedef struct packed {
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic din_ack;
    logic dout_ack;
    logic txd;
    logic dtr_n;
    logic rts_n;
  } tra_pins_type;

  localparam tra_pins_type PINS_RST = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

  // Half period of the terminal bit timing, rounded down
  function automatic logic [15:0] half_period(input logic [3:0] sel);
    int r;
    r = USER_BPS[(sel > 4'hA) ? 4'hA : sel];
    return 16'(CLK_HZ / (2 * r));
  endfunction
endpackage

/* File: verification/tra_net_model.sv */
// Network side partner: bit clock, frame sync and receive data; captures the time channel.
// Assumes window counter WIN_START falls on frame bit WIN_START+1; clock stops while i_en low.
`timescale 1ns/1ns
module tra_net_model #(
  parameter int FRAME_BITS = 64,
  parameter int WIN_START  = 24
) (
  input  wire logic        i_en,
  input  wire logic [7:0]  i_tx_byte,
  input  wire logic        i_net_serial_out,
  output logic             o_net_clk,
  output logic             o_frame_sync_8k,
  output logic             o_net_serial_in,
  output logic [7:0]       o_rx_byte,
  output logic [15:0]      o_frames,
  output logic [15:0]      o_idle_err
);
  logic [7:0] shift_q;

  initial begin
    o_net_clk = 1'b0;
    o_frame_sync_8k = 1'b0;
    o_net_serial_in = 1'b1;
    o_rx_byte = 8'hFF;
    o_frames = 16'h0000;
    o_idle_err = 16'h0000;
    shift_q = 8'hFF;
    forever begin
      if (!i_en) begin
        #80;
      end else begin
        for (int k = 0; k < FRAME_BITS; k++) begin
          #40 o_net_clk = 1'b1;
          #1;
          o_frame_sync_8k = (k == 0);
          if (k > WIN_START && k <= WIN_START + 8) begin
            o_net_serial_in = i_tx_byte[k - WIN_START - 1];
          end else begin
            o_net_serial_in = k[0];
          end
          #39 o_net_clk = 1'b0;
          if (k > WIN_START && k <= WIN_START + 8) begin
            shift_q[k - WIN_START - 1] = i_net_serial_out;
          end else if (o_frames >= 2 && i_net_serial_out !== 1'b1) begin
            o_idle_err++;
          end
        end
        o_rx_byte = shift_q;
        o_frames++;
        // Released line shows the inverse of its last bit
        o_net_serial_in = ~o_net_serial_in;
        #160;
      end
    end
  end
endmodule // tra_net_model

/* File: verification/tra_top_tb_top.sv */
// Self-checking bench for tra_top: reset, control, status, remote loop, USART FIFOs, bit timing.
// Assumes the network partner model and a 10 MHz system clock.
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tra_top_tb_top;
  logic                  clk_sys, rst, net_clk, fs, net_in, net_out, ad_oe, rxd, s_clk;
  logic                  irq_n, irq_oe, dreq_o, dreq_i, end_of_dma_out_req, frames_en, prev_s, prev_rxd;
  logic [7:0]            ad, ad_out, tx_byte, rx_byte, rx_data;
  logic [2:0]            ctl_n;
  logic [15:0]           frames, idle_err;
  logic [31:0]           rng;
  logic [7:0]            exp_q[$];
  tra_pkg::tra_cfg_type  cfg;
  tra_pkg::tra_pins_type pins;
  int                    bad_count, checked;

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  tra_top i_tra_top (.i_clk_sys(clk_sys), .i_rst(rst), .i_net_clk(net_clk),
    .i_frame_sync_8k(fs), .i_net_serial_in(net_in), .o_net_serial_out(net_out),
    .i_cfg(cfg), .i_pins(pins), .i_ad(ad), .o_ad_out(ad_out), .o_ad_oe(ad_oe),
    .o_term_rxd(rxd), .o_bit_timing(s_clk), .o_term_ctl_n(ctl_n), .o_irq_n_out(irq_n),
    .o_irq_oe(irq_oe), .o_dma_out_request(dreq_o), .o_dma_in_request(dreq_i),
    .o_end_of_dma_out_req(end_of_dma_out_req));

  tra_net_model i_tra_net_model (.i_en(frames_en), .i_tx_byte(tx_byte),
    .i_net_serial_out(net_out), .o_net_clk(net_clk), .o_frame_sync_8k(fs),
    .o_net_serial_in(net_in), .o_rx_byte(rx_byte), .o_frames(frames),
    .o_idle_err(idle_err));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic wait_s(input logic lvl);
    int c;
    c = 0;
    while (s_clk !== lvl && c < 40000) begin
      step(1);
      c++;
    end
    if (c >= 40000) bad_count++;
  endtask

  task automatic wait_frames(input int n);
    int f;
    int c;
    f = frames;
    c = 0;
    while (frames < f + n && c < 2000) begin
      step(1);
      c++;
    end
    if (c >= 2000) bad_count++;
  endtask

  task automatic bus_acc(input logic wr, input logic [7:0] addr, input logic [7:0] wdat,
                         output logic [7:0] data);
    pins.ale = 1'b1;
    ad = addr;
    step(3);
    pins.ale = 1'b0;
    ad = wr ? wdat : addr;
    step(1);
    pins.cs_n = 1'b0;
    pins.rd_n = wr;
    pins.wr_n = !wr;
    step(4);
    `CHK(ad_oe, !wr)
    data = ad_out;
    pins.rd_n = 1'b1;
    pins.wr_n = 1'b1;
    pins.cs_n = 1'b1;
    step(6);
  endtask

  // High half of the terminal bit timing, in system cycles
  task automatic half_check(input int sel);
    int c;
    int expc;
    cfg.rate_sel = sel[3:0];
    expc = tra_pkg::CLK_HZ / (2 * tra_pkg::USER_BPS[sel]);
    wait_s(1'b0);
    wait_s(1'b1);
    c = 0;
    while (s_clk === 1'b1 && c < 40000) begin
      step(1);
      c++;
    end
    `CHK(c, expc)
  endtask

  task end_of_test;
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(negedge clk_sys) begin
    if (!rst) begin
      if (rxd !== prev_rxd) `CHK({prev_s, s_clk}, 2'b10)
      `CHK({dreq_o, dreq_i, end_of_dma_out_req}, 3'b000)
    end
    prev_s = s_clk;
    prev_rxd = rxd;
  end

  initial begin
    #6_000_000;
    bad_count++;
    end_of_test;
  end

  initial begin
    cfg = '{n_exp: 2'h3, slot: 9'h010, subch: 3'h1, rate_sel: 4'hA,
            mode: tra_pkg::MODE_SYNC_THRU, x21bis: 1'b0, dma_en: 1'b0};
    pins = tra_pkg::PINS_RST;
    ad = 8'h00;
    rst = 1'b1;
    frames_en = 1'b1;
    tx_byte = 8'hFF;
    rng = 32'h0000_0008;
    bad_count = 0;
    checked = 0;
    prev_s = 1'b0;
    prev_rxd = 1'b1;
    step(2);
    `CHK({rxd, s_clk, ctl_n, irq_oe, ad_out}, {5'h17, 1'b0, 8'h00})
    rst = 1'b0;
    step(120);
    pins.dtr_n = 1'b0;
    step(8);
    `CHK(ctl_n[1:0], 2'h3)
    `CHK({irq_oe, irq_n}, 2'h2)
    bus_acc(1'b0, tra_pkg::ADDR_STAT, 8'h00, rx_data);
    `CHK(rx_data[0], 1'b1)
    `CHK(irq_oe, 1'b0)
    cfg.x21bis = 1'b1;
    pins.rts_n = 1'b0;
    step(8);
    `CHK(ctl_n[1:0], 2'h0)
    cfg.mode = tra_pkg::MODE_LOOP_REMOTE;
    for (int i = 0; i < 8; i++) begin
      rng = xorshift(rng);
      tx_byte = rng[7:0];
      exp_q.push_back(rng[7:0]);
      wait_frames(5);
      `CHK(rx_byte, exp_q.pop_front())
    end
    `CHK(idle_err, 16'h0000)
    // Written byte leaves in the frame after the write, then the idle word
    cfg.mode = tra_pkg::MODE_USART;
    wait_frames(1);
    rng = xorshift(rng);
    exp_q.push_back(rng[7:0]);
    bus_acc(1'b1, tra_pkg::ADDR_USART, rng[7:0], rx_data);
    wait_frames(2);
    `CHK(rx_byte, exp_q.pop_front())
    wait_frames(1);
    `CHK(rx_byte, tra_pkg::IDLE_WORD)
    bus_acc(1'b0, tra_pkg::ADDR_USART, 8'h00, rx_data);
    `CHK(rx_data, tx_byte)
    frames_en = 1'b0;
    cfg.mode = tra_pkg::MODE_SYNC_THRU;
    step(100);
    for (int sel = 0; sel < tra_pkg::NUM_RATES; sel++) begin
      if (sel == 0 || sel > 3) half_check(sel);
    end
    end_of_test;
  end
endmodule // tra_top_tb_top
